// file: inc/relay_pkg.sv
package relay_pkg;

  // timing base
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_MS     = 50;
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int NUM_FIXED   = 5;
  localparam int FIXED_CNT_W = 10;
  // half periods of the fixed clocks in ms: 0.1 s, 0.2 s, 1 s, 2 s, 60 s
  localparam int HALF_MS [NUM_FIXED] = '{50, 100, 500, 1000, 30000};

  // programs and user clocks
  localparam int NUM_PROG  = 3;
  localparam int NUM_UCLK  = 2;
  localparam int UCNT_W    = 16;
  localparam logic [UCNT_W-1:0] UCLK_PRESET_RST = 16'h0001;

  // bus map: area = program (address bits [6:5]), word = address bits [4:2]
  localparam int ADDR_W = 8;
  localparam logic [1:0] AREA_MAX    = 2'h2;
  localparam logic [2:0] WORD_STATUS = 3'h0;
  localparam logic [2:0] WORD_STOP   = 3'h2;
  localparam logic [2:0] WORD_MODE   = 3'h3;
  localparam logic [2:0] WORD_RUN    = 3'h4;
  localparam logic [2:0] WORD_FLAGS  = 3'h5;
  localparam logic [2:0] WORD_CLOCK  = 3'h7;
  localparam logic [7:0] ADDR_UCLK0  = 8'hC0;
  localparam logic [7:0] ADDR_UCLK1  = 8'hC4;

  // bit positions inside the words
  localparam int BIT_MAJOR      = 1;
  localparam int BIT_MINOR      = 2;
  localparam int BIT_ALARM      = 3;
  localparam int BIT_ONE        = 4;
  localparam int BIT_ZERO_CONST = 5;
  localparam int BIT_FIRST      = 6;
  localparam int BIT_DSTOPPED   = 4;
  localparam int BIT_STOPREQ    = 5;
  localparam int BIT_STOPPED    = 6;
  localparam int BIT_RUN        = 7;
  localparam int BIT_DIVIDED    = 8;
  localparam int BIT_AUTOCLR    = 9;
  localparam int BIT_BACKUP     = 10;
  localparam int BIT_ER         = 0;
  localparam int BIT_LT         = 1;
  localparam int BIT_EQ         = 2;
  localparam int BIT_GT         = 3;
  localparam int BIT_ZF         = 4;
  localparam int BIT_BORROW     = 5;
  localparam int BIT_CARRY      = 6;
  localparam int BIT_DECLR      = 14;
  localparam int BIT_BKSTART    = 15;
  localparam int BIT_SCANCLK    = 8;
  localparam int BIT_UCLK       = 9;

endpackage : relay_pkg

// file: core/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
  parameter int CYCLES = 1000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == CW'(CYCLES - 1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // tick_divider

`default_nettype wire

// file: core/special_relays.sv
`timescale 1ns/10ps
`default_nettype none

module special_relays
  import relay_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [ADDR_W-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // cpu executive
  input  wire logic                run_reset,
  input  wire logic                error_reset,
  input  wire logic                major_err,
  input  wire logic                minor_err,
  input  wire logic                alarm_active,
  input  wire logic                end_of_scan,
  input  wire logic                dummy_stop_req,
  input  wire logic                dummy_stop_exec,
  input  wire logic                scan_running,
  input  wire logic                step_mode,
  input  wire logic [NUM_PROG-1:0] prog_exec,
  input  wire logic                mem_divided,
  input  wire logic [NUM_PROG-1:0] arith_flag_autoclear_mode,
  input  wire logic                data_err_detect,
  // applied instruction results
  input  wire logic [1:0]          instr_prog,
  input  wire logic                instr_done,
  input  wire logic                instr_confined,
  input  wire logic                instr_failed,
  input  wire logic                cmp_valid,
  input  wire logic                cmp_lt,
  input  wire logic                cmp_eq,
  input  wire logic                cmp_gt,
  input  wire logic                arith_valid,
  input  wire logic                arith_zero,
  input  wire logic                arith_borrow,
  input  wire logic                arith_carry,
  // backup engine
  input  wire logic                backup_done,
  output logic                     backup_start,
  output logic                     data_err_uncheck
);

  typedef logic [NUM_PROG-1:0] pvec_t;

  typedef struct packed {
    logic                                  major_fault_state;
    logic                                  minor_fault_state;
    logic                                  alarm_output_state;
    logic                                  first_scan;
    logic                                  stop_req;
    logic                                  dummy_stopped;
    logic                                  stopped;
    logic                                  run;
    logic                                  divided;
    pvec_t                                 autoclr;
    pvec_t                                 prog_run;
    pvec_t                                 instr_error_flag;
    pvec_t                                 lt;
    pvec_t                                 eq;
    pvec_t                                 gt;
    pvec_t                                 zero;
    pvec_t                                 borrow_flag;
    pvec_t                                 carry_flag;
    logic                                  err_clear_ctl;
    logic                                  backup_ctl;
    logic                                  backup_busy;
    logic                                  backup_go;
    logic                                  uncheck;
    logic [NUM_FIXED-1:0]                  fixed_clk;
    logic [NUM_FIXED-1:0][FIXED_CNT_W-1:0] fixed_cnt;
    logic                                  scan_clk;
    logic [NUM_UCLK-1:0]                   uclk;
    logic [NUM_UCLK-1:0][UCNT_W-1:0]       ucnt;
    logic [NUM_UCLK-1:0][UCNT_W-1:0]       uhigh;
    logic [NUM_UCLK-1:0][UCNT_W-1:0]       ulow;
    logic                                  wr_pend;
    logic [ADDR_W-1:0]                     wr_addr;
    logic [31:0]                           rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic   tick;

  // single time base for every fixed clock keeps them phase-locked
  tick_divider #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  function automatic logic [31:0] read_word(input state_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    logic [1:0]  area;
    logic [2:0]  word;
    w    = 32'h0000_0000;
    area = a[6:5];
    word = a[4:2];
    if (a == ADDR_UCLK0) begin
      w = {s.ulow[0], s.uhigh[0]};
    end else if (a == ADDR_UCLK1) begin
      w = {s.ulow[1], s.uhigh[1]};
    end else if (a[7] == 1'b0 && area <= AREA_MAX) begin
      if (word == WORD_FLAGS) begin
        // arithmetic flags exist in every program area
        w[BIT_ER]     = s.instr_error_flag[area];
        w[BIT_LT]     = s.lt[area];
        w[BIT_EQ]     = s.eq[area];
        w[BIT_GT]     = s.gt[area];
        w[BIT_ZF]     = s.zero[area];
        w[BIT_BORROW] = s.borrow_flag[area];
        w[BIT_CARRY]  = s.carry_flag[area];
        if (area == 2'h0) begin
          w[BIT_DECLR]   = s.err_clear_ctl;
          w[BIT_BKSTART] = s.backup_ctl;
        end
      end else if (word == WORD_MODE && area != 2'h0) begin
        w[BIT_AUTOCLR] = s.autoclr[area];
      end else if (area == 2'h0) begin
        // everything else only in program one; the autoclear bit also sits in the other areas' mode words
        unique case (word)
          WORD_STATUS: begin
            w[BIT_MAJOR]      = s.major_fault_state;
            w[BIT_MINOR]      = s.minor_fault_state;
            w[BIT_ALARM]      = s.alarm_output_state;
            w[BIT_ONE]        = 1'b1;
            w[BIT_ZERO_CONST] = 1'b0;
            w[BIT_FIRST]      = s.first_scan;
          end
          WORD_STOP: begin
            w[BIT_DSTOPPED] = s.dummy_stopped;
            w[BIT_STOPREQ]  = s.stop_req;
            w[BIT_STOPPED]  = s.stopped;
            w[BIT_RUN]      = s.run;
          end
          WORD_MODE: begin
            w[BIT_DIVIDED] = s.divided;
            w[BIT_AUTOCLR] = s.autoclr[0];
            w[BIT_BACKUP]  = s.backup_busy;
          end
          WORD_RUN: begin
            w[NUM_PROG-1:0] = s.prog_run;
          end
          WORD_CLOCK: begin
            w[NUM_FIXED-1:0]                  = s.fixed_clk;
            w[BIT_SCANCLK]                    = s.scan_clk;
            w[BIT_UCLK+NUM_UCLK-1:BIT_UCLK]   = s.uclk;
          end
          default: w = 32'h0000_0000;
        endcase
      end
    end
    return w;
  endfunction

  always_comb begin
    logic [1:0]        p;
    logic              take;
    logic [UCNT_W-1:0] lim;
    p                 = 2'h0;
    take              = 1'b0;
    lim               = '0;
    next_st           = st;
    next_st.backup_go = 1'b0;

    // fault and alarm bits, a new event wins over a reset in the same cycle
    next_st.major_fault_state  = major_err | (st.major_fault_state & ~error_reset);
    next_st.minor_fault_state  = minor_err | (st.minor_fault_state & ~error_reset);
    next_st.alarm_output_state = alarm_active | (st.alarm_output_state & ~error_reset);

    // run-state bits
    if (run_reset) begin
      next_st.first_scan    = 1'b1;
      next_st.stop_req      = 1'b0;
      next_st.dummy_stopped = 1'b0;
    end else if (end_of_scan) begin
      next_st.first_scan = 1'b0;
    end
    // set wins: a stop event in the reset cycle still lands
    if (dummy_stop_req) begin
      next_st.stop_req = 1'b1;
    end
    if (dummy_stop_exec) begin
      next_st.dummy_stopped = 1'b1;
    end
    next_st.stopped  = ~scan_running | step_mode;
    next_st.run      = |prog_exec;
    next_st.prog_run = prog_exec;
    next_st.divided  = mem_divided;
    next_st.autoclr  = arith_flag_autoclear_mode;

    // single mode folds every program onto the first area
    p = mem_divided ? instr_prog : 2'h0;
    if (p > AREA_MAX) begin
      p = 2'h0;
    end
    if (instr_done && instr_confined) begin
      next_st.instr_error_flag[p] = instr_failed;
    end
    if (cmp_valid) begin
      next_st.lt[p] = cmp_lt;
      next_st.eq[p] = cmp_eq;
      next_st.gt[p] = cmp_gt;
    end
    if (arith_valid) begin
      next_st.zero[p]        = arith_zero;
      next_st.borrow_flag[p] = arith_borrow;
      next_st.carry_flag[p]  = arith_carry;
    end

    // fixed clocks count shared ticks
    // the 60 s count is the longest and sets the counter width
    for (int i = 0; i < NUM_FIXED; i++) begin
      if (tick) begin
        if (st.fixed_cnt[i] == FIXED_CNT_W'(HALF_MS[i] / TICK_MS - 1)) begin
          next_st.fixed_cnt[i] = '0;
          next_st.fixed_clk[i] = ~st.fixed_clk[i];
        end else begin
          next_st.fixed_cnt[i] = st.fixed_cnt[i] + 1'b1;
        end
      end
    end

    // scan clock and user clocks advance on end of scan
    if (end_of_scan) begin
      next_st.scan_clk = ~st.scan_clk;
      for (int u = 0; u < NUM_UCLK; u++) begin
        lim = st.uclk[u] ? st.uhigh[u] : st.ulow[u];
        // a preset of zero behaves as one scan, so the clock never sticks
        if (st.ucnt[u] + 1'b1 >= lim) begin
          next_st.ucnt[u] = '0;
          next_st.uclk[u] = ~st.uclk[u];
        end else begin
          next_st.ucnt[u] = st.ucnt[u] + 1'b1;
        end
      end
    end

    // bus data phase: a write lands one cycle after its address phase
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      if (st.wr_addr == ADDR_UCLK0 || st.wr_addr == ADDR_UCLK1) begin
        next_st.uhigh[st.wr_addr[2]] = hwdata[UCNT_W-1:0];
        next_st.ulow[st.wr_addr[2]]  = hwdata[31:UCNT_W];
        next_st.ucnt[st.wr_addr[2]]  = '0;
      end else if (st.wr_addr[7:2] == {3'h0, WORD_FLAGS}) begin
        next_st.err_clear_ctl = hwdata[BIT_DECLR];
        next_st.backup_ctl    = hwdata[BIT_BKSTART];
        if (st.backup_ctl && !hwdata[BIT_BKSTART]) begin
          next_st.backup_go = 1'b1;
        end
      end
      // other addresses are reserved and writes there are dropped
    end

    // backup runs from launch until the engine reports done
    if (next_st.backup_go) begin
      next_st.backup_busy = 1'b1;
    end else if (backup_done) begin
      next_st.backup_busy = 1'b0;
    end

    // clear bit held on keeps clearing; a fresh detection still wins
    if (data_err_detect) begin
      next_st.uncheck = 1'b1;
    end else if (st.err_clear_ctl) begin
      next_st.uncheck = 1'b0;
    end

    // address phase
    // hready low means another slave's data phase is still running
    take = hsel & htrans[1] & hready;
    if (take && hwrite) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_addr = haddr;
    end
    if (take && !hwrite) begin
      next_st.rdata = read_word(st, haddr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st            <= '0;
      st.first_scan <= 1'b1;
      st.stopped    <= 1'b1;
      // presets of one make both user clocks plain scan toggles after reset
      st.uhigh      <= {NUM_UCLK{UCLK_PRESET_RST}};
      st.ulow       <= {NUM_UCLK{UCLK_PRESET_RST}};
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st.rdata;
  assign backup_start     = st.backup_go;
  assign data_err_uncheck = st.uncheck;

endmodule // special_relays

`default_nettype wire

// file: test/relays_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module relays_monitor
  import relay_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              major_err,
  input wire logic              error_reset,
  input wire logic              data_err_detect,
  input wire logic              backup_start,
  input wire logic              data_err_uncheck
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd;
  logic wr;
  logic bk_wr;
  logic bk_low;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign wr = hsel && htrans[1] && hready && hwrite && haddr == 8'h14;
  // remembers a write to the control word so its data phase can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bk_wr <= 1'b0;
    end else begin
      bk_wr <= wr;
    end
  end
  assign bk_low = bk_wr && !hwdata[BIT_BKSTART];
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stalled or answered with error");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_const; rd && haddr == 8'h00 |=> hrdata[BIT_ONE] && !hrdata[BIT_ZERO_CONST]; endproperty
  a_const: assert property (p_const) else $error("constant bits wrong");
  property p_unmapped; rd && haddr >= 8'h60 && haddr < 8'hC0 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("missing area read not zero");
  property p_major;
    rd && haddr == 8'h00 && $past(major_err, 3) && !$past(error_reset, 1)
      && !$past(error_reset, 2) |=> hrdata[BIT_MAJOR];
  endproperty
  a_major: assert property (p_major) else $error("major fault bit not set");
  property p_uncheck; data_err_detect |-> ##[1:3] data_err_uncheck; endproperty
  a_uncheck: assert property (p_uncheck) else $error("data error alarm not raised");
  property p_bk_pulse; backup_start |=> !backup_start; endproperty
  a_bk_pulse: assert property (p_bk_pulse) else $error("backup start longer than one cycle");
  property p_bk_cause;
    $rose(backup_start) |-> $past(bk_low, 1) || $past(bk_low, 2);
  endproperty
  a_bk_cause: assert property (p_bk_cause) else $error("backup started without falling bit");
endmodule // relays_monitor
bind special_relays relays_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .major_err, .error_reset, .data_err_detect,
  .backup_start, .data_err_uncheck);
`default_nettype wire

// file: test/backup_engine.sv
`timescale 1ns/10ps
`default_nettype none
module backup_engine (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic backup_start,
  input  wire logic slow,
  output logic      backup_done
);
  int cnt;
  // slow mode keeps the busy window open long enough to be read twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      backup_done <= 1'b0;
    end else begin
      backup_done <= (cnt == 1);
      if (backup_start) begin
        cnt <= slow ? 40 : 2;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // backup_engine
`default_nettype wire

// file: test/special_relays_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module special_relays_tb;
  import relay_pkg::*;
  localparam int TK = 4;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, backup_done, prev;
  logic        run_reset, error_reset, major_err, minor_err, alarm_active, end_of_scan;
  logic        dummy_stop_req, dummy_stop_exec, scan_running, step_mode, mem_divided;
  logic        data_err_detect, instr_done, instr_confined, instr_failed, cmp_valid;
  logic        cmp_lt, cmp_eq, cmp_gt, arith_valid, arith_zero, arith_borrow, arith_carry;
  logic        backup_start, data_err_uncheck;
  logic [1:0]  htrans, instr_prog;
  logic [2:0]  prog_exec, arith_flag_autoclear_mode;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, q;
  logic [15:0] rnd;
  int          err_count, compares, cyc, t1, want;
  special_relays #(.TICK_CYC(TK)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .run_reset,
    .error_reset, .major_err, .minor_err, .alarm_active, .end_of_scan, .dummy_stop_req,
    .dummy_stop_exec, .scan_running, .step_mode, .prog_exec, .mem_divided,
    .arith_flag_autoclear_mode, .data_err_detect, .instr_prog, .instr_done, .instr_confined,
    .instr_failed, .cmp_valid, .cmp_lt, .cmp_eq, .cmp_gt, .arith_valid, .arith_zero,
    .arith_borrow, .arith_carry, .backup_done, .backup_start, .data_err_uncheck);
  backup_engine partner (.hclk, .hresetn, .backup_start, .slow, .backup_done);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) cyc++;
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1500000;
    err_count++;
    test_done;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic eos;
    @(posedge hclk);
    end_of_scan <= 1'b1;
    @(posedge hclk);
    end_of_scan <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic apply(input logic [1:0] p);
    rnd = lfsr(rnd);
    @(posedge hclk);
    {instr_done, instr_confined, cmp_valid, arith_valid} <= 4'hF;
    instr_prog <= p;
    {arith_carry, arith_borrow, arith_zero, cmp_gt, cmp_eq, cmp_lt, instr_failed} <= rnd[6:0];
    @(posedge hclk);
    {instr_done, instr_confined, cmp_valid, arith_valid} <= 4'h0;
    repeat (3) @(posedge hclk);
    // single mode keeps one flag set, in program one's area
    bus(1'b0, mem_divided ? 8'h14 + 8'(p) * 8'h20 : 8'h14, 32'h0);
  endtask
  initial begin
    {hsel, hwrite, slow, run_reset, error_reset, major_err, minor_err, alarm_active} = '0;
    {end_of_scan, dummy_stop_req, dummy_stop_exec, scan_running, step_mode} = '0;
    {mem_divided, data_err_detect, instr_done, instr_confined, instr_failed, cmp_valid} = '0;
    {cmp_lt, cmp_eq, cmp_gt, arith_valid, arith_zero, arith_borrow, arith_carry} = '0;
    {htrans, instr_prog, prog_exec, arith_flag_autoclear_mode, haddr, hwdata} = '0;
    hresetn = 1'b0;
    rnd = 16'hDE05;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0); `CHK(q, 32'h50)
    eos;
    bus(1'b0, 8'h00, 32'h0); `CHK(q, 32'h10)
    @(posedge hclk) dummy_stop_req <= 1'b1;
    @(posedge hclk) dummy_stop_req <= 1'b0;
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h60)
    @(posedge hclk) dummy_stop_exec <= 1'b1;
    @(posedge hclk) dummy_stop_exec <= 1'b0;
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h70)
    @(posedge hclk) run_reset <= 1'b1;
    @(posedge hclk) run_reset <= 1'b0;
    bus(1'b0, 8'h08, 32'h0); `CHK(q, 32'h40)
    bus(1'b0, 8'h00, 32'h0); `CHK(q, 32'h50)
    @(posedge hclk) {major_err, minor_err, alarm_active} <= 3'h7;
    repeat (3) @(posedge hclk);
    {major_err, minor_err, alarm_active} <= 3'h0;
    bus(1'b0, 8'h00, 32'h0); `CHK(q[3:1], 3'h7)
    @(posedge hclk) error_reset <= 1'b1;
    @(posedge hclk) error_reset <= 1'b0;
    bus(1'b0, 8'h00, 32'h0); `CHK(q[3:1], 3'h0)
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      @(posedge hclk);
      {arith_flag_autoclear_mode, mem_divided, prog_exec, step_mode, scan_running} <= rnd[8:0];
      repeat (3) @(posedge hclk);
      bus(1'b0, 8'h08, 32'h0); `CHK(q[6], !rnd[0] || rnd[1])
      `CHK(q[7], |rnd[4:2])
      bus(1'b0, 8'h10, 32'h0); `CHK(q[2:0], rnd[4:2])
      bus(1'b0, 8'h0C, 32'h0); `CHK(q[9:8], rnd[6:5])
      bus(1'b0, 8'h2C, 32'h0); `CHK(q[9], rnd[7])
      bus(1'b0, 8'h4C, 32'h0); `CHK(q[9], rnd[8])
    end
    bus(1'b0, 8'h60, 32'h0); `CHK(q, 32'h0)
    @(posedge hclk) mem_divided <= 1'b1;
    for (int p = 0; p < NUM_PROG; p++) begin
      apply(2'(p)); `CHK(q[6:0], rnd[6:0])
    end
    @(posedge hclk) mem_divided <= 1'b0;
    apply(2'h2); `CHK(q[6:0], rnd[6:0])
    @(posedge hclk) data_err_detect <= 1'b1;
    @(posedge hclk) data_err_detect <= 1'b0;
    repeat (3) @(posedge hclk); `CHK(data_err_uncheck, 1'b1)
    bus(1'b1, 8'h14, 32'h4000);
    repeat (3) @(posedge hclk); `CHK(data_err_uncheck, 1'b0)
    for (int s = 1; s >= 0; s--) begin
      slow <= s[0];
      bus(1'b1, 8'h14, 32'h8000);
      bus(1'b1, 8'h14, 32'h0);
      bus(1'b0, 8'h0C, 32'h0); `CHK(q[10], 1'b1)
      repeat (50) @(posedge hclk);
      bus(1'b0, 8'h0C, 32'h0); `CHK(q[10], 1'b0)
    end
    // the one earlier end of scan left both user clocks high; a preset only restarts the count
    bus(1'b1, ADDR_UCLK0, 32'h0001_0002);
    for (int k = 0; k < 6; k++) begin
      eos;
      bus(1'b0, 8'h1C, 32'h0);
      if (k > 0) `CHK(q[8], !prev)
      `CHK(q[9], (k % 3) != 1)
      `CHK(q[10], k[0])
      prev = q[8];
    end
    // reads take a few cycles, so edges are only known to within a read
    for (int b = 0; b < NUM_FIXED; b++) begin
      want = HALF_MS[b] / TICK_MS * TK;
      bus(1'b0, 8'h1C, 32'h0);
      prev = q[b];
      do bus(1'b0, 8'h1C, 32'h0); while (q[b] === prev);
      t1 = cyc;
      prev = q[b];
      do bus(1'b0, 8'h1C, 32'h0); while (q[b] === prev);
      `CHK((cyc - t1 >= want - 5) && (cyc - t1 <= want + 5), 1'b1)
    end
    test_done;
  end
endmodule // special_relays_tb
`default_nettype wire
